// file: hdl/prot_defs.svh
/*
 * Offsets, bit positions and reset values of the link and of the
 * controller's Avalon-MM registers.
 * Assumes inclusion by bare name before any use.
 */
`ifndef PROT_DEFS_SVH
`define PROT_DEFS_SVH

// register offsets on the link, byte addresses
`define CTRL_OFS       8'h64
`define BASE_OFS       8'h68
`define LIMIT_OFS      8'h6c

// protect control register fields
`define EN_BIT         31
`define STATE_BIT      0
`define RSVD_HI        30
`define RSVD_LO        1

`define REG_RESET      32'h0000_0000
`define MIN_VER_BLOCK  4'h2

// controller registers, Avalon-MM word index
`define H_LADDR        3'h0
`define H_LWDATA       3'h1
`define H_GO           3'h2
`define H_DADDR        3'h3
`define H_STATUS       3'h4
`define H_LRDATA       3'h5

// go register fields
`define GO_WR          0
`define GO_RD          1
`define GO_DMA         2
`define GO_SRC_LO      4
`define GO_SRC_HI      5

// status register fields
`define ST_BUSY        0
`define ST_BLOCKED     1
`define ST_REFUSED     2
`define ST_BASE_DONE   3

`endif

// file: hdl/prot_pkg.sv
/*
 * Types shared by both ends of the protected low-region link.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package prot_pkg;
    // origin of a request arriving at the protection check
    typedef enum logic [1:0] {
        src_pci       = 2'h0,
        src_cxl_io    = 2'h1,
        src_cxl_cache = 2'h2,
        src_walk      = 2'h3
    } dma_source_type;

    typedef enum logic [2:0] {
        st_off   = 3'h1,
        st_drain = 3'h2,
        st_on    = 3'h4
    } guard_state_type;

    typedef enum logic [2:0] {
        h_idle = 3'h1,
        h_reg  = 3'h2,
        h_dma  = 3'h4
    } host_state_type;
endpackage

`default_nettype wire

// file: hdl/prot_link_if.sv
/*
 * Link between the two ends: register and request channels, each a held
 * request with a one-cycle answer.
 * Assumes both ends run on the same clock.
 */
`default_nettype none

interface prot_link_if;
    // register channel
    logic                       reg_req;
    logic                       reg_write;
    logic [7:0]                 reg_addr;
    logic [31:0]                reg_wdata;
    logic                       reg_ack;
    logic [31:0]                reg_rdata;
    // request channel
    logic                       dma_req;
    prot_pkg::dma_source_type   dma_src;
    logic [31:0]                dma_addr;
    logic                       dma_done;
    logic                       dma_blocked;
    // protection state as seen by the requesting side
    logic                       prot_state;

    modport device_end (
        input  reg_req, reg_write, reg_addr, reg_wdata,
        output reg_ack, reg_rdata,
        input  dma_req, dma_src, dma_addr,
        output dma_done, dma_blocked, prot_state
    );

    modport host_end (
        output reg_req, reg_write, reg_addr, reg_wdata,
        input  reg_ack, reg_rdata,
        output dma_req, dma_src, dma_addr,
        input  dma_done, dma_blocked, prot_state
    );
endinterface

`default_nettype wire

// file: hdl/region_match.sv
/*
 * Range check of one address against a decoded base and limit.
 * Assumes base and limit already carry their decoded low bits.
 */
`default_nettype none

module region_match #(
    parameter int W = 32
) (
    // range and address
    input  wire logic [W-1:0] base,
    input  wire logic [W-1:0] limit,
    input  wire logic [W-1:0] addr,
    // result
    output logic              hit
);
    logic valid_range;

    assign valid_range = (limit >= base);
    assign hit = valid_range && (addr >= base) && (addr <= limit);
endmodule

`default_nettype wire

// file: hdl/prot_guard.sv
/*
 * Device end: protect control, low-region base and limit registers and the
 * block decision for link requests.
 * Assumes one clock shared with the requesting side and the datapath.
 */
// Notes on behaviour
// - bit 31 enables the protected low region
// - version two or later blocks regardless of remapping
// - CXL.cache accesses are never checked
// - CXL.cache software guards memory via page tables
// - own table walks bypass the region check
// - blocked requests raise no fault record
// - status bit 0 shows completed enable state
// - drain in-flight translated requests before status set
// - software programs base before enabling
// - no base writes while status shows enabled
// - base read-only without low-region capability
// - base low bits read zero, decode zero
// - all-ones write reveals alignment by readback
// - low region lies below 4GB
// - base upper bits read-write, reset zero
// - limit low bits decode as ones
// - limit below base disables low region
`include "prot_defs.svh"
`default_nettype none

module prot_guard #(
    parameter logic [3:0] VERSION_MAJOR        = 4'h2,
    parameter bit         LOW_REGION_SUPPORTED = 1'b1,
    parameter bit         DRAIN_SUPPORTED      = 1'b1,
    parameter int         RSVD_MSB             = 19
) (
    // clock, reset, enable
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        ce,
    // link to the requesting side
    prot_link_if.device_end  link,
    // remapping datapath
    input  wire logic        remap_enable,
    input  wire logic        inflight_empty,
    input  wire logic        remap_fault,
    output logic             drain_request,
    output logic             fault_report,
    output logic             protect_state
);
    import prot_pkg::*;

    localparam logic [31:0] FIELD_MASK =
        ~((32'h0000_0001 << (RSVD_MSB + 1)) - 32'h0000_0001);

    guard_state_type state_q;
    guard_state_type state_d;
    logic            enable_q;
    logic [29:0]     rsvd_q;
    logic [31:0]     base_q;
    logic [31:0]     limit_q;
    logic            ack_q;
    logic [31:0]     rdata_q;
    logic [31:0]     rdata_d;
    logic            done_q;
    logic            blocked_q;
    logic            drain_q;
    logic            prot_q;
    logic            fault_q;
    logic            reg_take;
    logic            reg_wr;
    logic            dma_take;
    logic            hit;
    logic            checked_src;
    logic            version_ok;
    logic            block_now;

    assign reg_take = link.reg_req && !ack_q;
    assign reg_wr   = reg_take && link.reg_write;
    assign dma_take = link.dma_req && !done_q;

    // enable and reserved bits of the protect control register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            enable_q <= 1'b0;
            rsvd_q   <= 30'h0000_0000;
        end else if (ce && reg_wr && link.reg_addr == `CTRL_OFS) begin
            enable_q <= link.reg_wdata[`EN_BIT];
            rsvd_q   <= link.reg_wdata[`RSVD_HI:`RSVD_LO];
        end
    end

    // base and limit hold only their upper field; a write without the
    // capability is dropped so the registers behave as read-only
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            base_q  <= `REG_RESET;
            limit_q <= `REG_RESET;
        end else if (ce && reg_wr && LOW_REGION_SUPPORTED) begin
            if (link.reg_addr == `BASE_OFS) begin
                base_q <= link.reg_wdata & FIELD_MASK;
            end
            if (link.reg_addr == `LIMIT_OFS) begin
                limit_q <= link.reg_wdata & FIELD_MASK;
            end
        end
    end

    always_comb begin
        case (state_q)
            st_off: begin
                if (enable_q) begin
                    state_d = DRAIN_SUPPORTED ? st_drain : st_on;
                end else begin
                    state_d = st_off;
                end
            end
            st_drain: begin
                if (!enable_q) begin
                    state_d = st_off;
                end else if (inflight_empty) begin
                    state_d = st_on;
                end else begin
                    state_d = st_drain;
                end
            end
            st_on: begin
                state_d = enable_q ? st_on : st_off;
            end
            default: begin
                state_d = st_off;
            end
        endcase
    end

    // the status bit follows only once the enable has taken full effect
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q <= st_off;
            drain_q <= 1'b0;
            prot_q  <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            drain_q <= (state_d == st_drain);
            prot_q  <= (state_d == st_on);
        end
    end

    always_comb begin
        rdata_d = `REG_RESET;
        case (link.reg_addr)
            `CTRL_OFS: begin
                rdata_d[`EN_BIT]              = enable_q;
                rdata_d[`RSVD_HI:`RSVD_LO]    = rsvd_q;
                rdata_d[`STATE_BIT]           = prot_q;
            end
            `BASE_OFS: begin
                rdata_d = base_q & FIELD_MASK;
            end
            `LIMIT_OFS: begin
                rdata_d = limit_q & FIELD_MASK;
            end
            default: begin
                rdata_d = `REG_RESET;
            end
        endcase
    end

    // register channel: answer one cycle after the request is taken
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ack_q   <= 1'b0;
            rdata_q <= `REG_RESET;
        end else if (ce) begin
            ack_q <= reg_take;
            if (reg_take) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // decoded range: base low bits as zeros, limit low bits as ones
    region_match #(
        .W     (32)
    ) u_low_match (
        .base  (base_q & FIELD_MASK),
        .limit (limit_q | ~FIELD_MASK),
        .addr  (link.dma_addr),
        .hit   (hit)
    );

    // CXL.cache and the unit's own structure walks never reach the check
    assign checked_src = (link.dma_src == src_pci) ||
                         (link.dma_src == src_cxl_io);
    // older versions leave remapped traffic to the page tables
    assign version_ok  = (VERSION_MAJOR >= `MIN_VER_BLOCK) ||
                         !remap_enable;
    assign block_now   = checked_src && enable_q && hit && version_ok;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            done_q    <= 1'b0;
            blocked_q <= 1'b0;
        end else if (ce) begin
            done_q <= dma_take;
            if (dma_take) begin
                blocked_q <= block_now;
            end
        end
    end

    // a fault from the datapath on a request that is being blocked is
    // swallowed: the block itself is silent
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fault_q <= 1'b0;
        end else if (ce) begin
            fault_q <= remap_fault && !(dma_take && block_now);
        end
    end

    assign link.reg_ack     = ack_q;
    assign link.reg_rdata   = rdata_q;
    assign link.dma_done    = done_q;
    assign link.dma_blocked = blocked_q;
    assign link.prot_state  = prot_q;
    assign drain_request    = drain_q;
    assign fault_report     = fault_q;
    assign protect_state    = prot_q;
endmodule

`default_nettype wire

// file: hdl/prot_host.sv
/*
 * Requesting end: Avalon-MM orders become link accesses and test requests.
 * Assumes the device end on the same clock answers every request.
 */
`include "prot_defs.svh"
`default_nettype none

module prot_host (
    // clock, reset, enable
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        ce,
    // Avalon-MM slave
    input  wire logic [2:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    // link to the device end
    prot_link_if.host_end    link
);
    import prot_pkg::*;

    host_state_type state_q;
    logic           wait_q;
    logic [31:0]    readdata_q;
    logic [31:0]    readdata_d;
    logic [7:0]     laddr_q;
    logic [31:0]    lwdata_q;
    logic [31:0]    daddr_q;
    logic [31:0]    lrdata_q;
    logic [31:0]    shadow_q;
    logic           base_done_q;
    logic           blocked_q;
    logic           refused_q;
    logic           req_q;
    logic           rw_q;
    logic [31:0]    wdata_q;
    logic           dreq_q;
    dma_source_type src_q;
    logic           bus_wr;
    logic           go;
    logic           refuse;

    assign bus_wr = write && !wait_q;
    assign go     = bus_wr && address == `H_GO;
    // region registers are frozen while the device reports enabled, and
    // enabling before the base is programmed is held back
    assign refuse = writedata[`GO_WR] && (
        ((laddr_q == `BASE_OFS || laddr_q == `LIMIT_OFS) &&
         link.prot_state) ||
        (laddr_q == `CTRL_OFS && lwdata_q[`EN_BIT] && !base_done_q));

    // one wait cycle per access, answer at the following edge
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wait_q     <= 1'b1;
            readdata_q <= `REG_RESET;
        end else if (ce) begin
            if (!wait_q) begin
                wait_q <= 1'b1;
            end else if (read || write) begin
                wait_q     <= 1'b0;
                readdata_q <= readdata_d;
            end
        end
    end

    always_comb begin
        readdata_d = `REG_RESET;
        case (address)
            `H_LADDR:  readdata_d[7:0] = laddr_q;
            `H_LWDATA: readdata_d = lwdata_q;
            `H_DADDR:  readdata_d = daddr_q;
            `H_LRDATA: readdata_d = lrdata_q;
            `H_STATUS: begin
                readdata_d[`ST_BUSY]      = (state_q != h_idle);
                readdata_d[`ST_BLOCKED]   = blocked_q;
                readdata_d[`ST_REFUSED]   = refused_q;
                readdata_d[`ST_BASE_DONE] = base_done_q;
            end
            default:   readdata_d = `REG_RESET;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            laddr_q  <= 8'h00;
            lwdata_q <= `REG_RESET;
            daddr_q  <= `REG_RESET;
        end else if (ce && bus_wr) begin
            if (address == `H_LADDR) begin
                laddr_q <= writedata[7:0];
            end
            if (address == `H_LWDATA) begin
                lwdata_q <= writedata;
            end
            if (address == `H_DADDR) begin
                daddr_q <= writedata;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q     <= h_idle;
            req_q       <= 1'b0;
            rw_q        <= 1'b0;
            wdata_q     <= `REG_RESET;
            dreq_q      <= 1'b0;
            src_q       <= src_pci;
            lrdata_q    <= `REG_RESET;
            shadow_q    <= `REG_RESET;
            base_done_q <= 1'b0;
            blocked_q   <= 1'b0;
            refused_q   <= 1'b0;
        end else if (ce) begin
            case (state_q)
                h_idle: begin
                    if (go && refuse) begin
                        refused_q <= 1'b1;
                    end else if (go && (writedata[`GO_WR] ||
                                        writedata[`GO_RD])) begin
                        refused_q <= 1'b0;
                        req_q     <= 1'b1;
                        rw_q      <= writedata[`GO_WR];
                        wdata_q   <= lwdata_q;
                        if (laddr_q == `CTRL_OFS) begin
                            // reserved bits go back as last read
                            wdata_q[`RSVD_HI:`RSVD_LO] <=
                                shadow_q[`RSVD_HI:`RSVD_LO];
                        end
                        state_q <= h_reg;
                    end else if (go && writedata[`GO_DMA]) begin
                        refused_q <= 1'b0;
                        dreq_q    <= 1'b1;
                        src_q     <= dma_source_type'(
                            writedata[`GO_SRC_HI:`GO_SRC_LO]);
                        state_q   <= h_dma;
                    end
                end
                h_reg: begin
                    if (link.reg_ack) begin
                        req_q    <= 1'b0;
                        lrdata_q <= link.reg_rdata;
                        if (!rw_q && laddr_q == `CTRL_OFS) begin
                            shadow_q <= link.reg_rdata;
                        end
                        if (rw_q && laddr_q == `BASE_OFS) begin
                            base_done_q <= 1'b1;
                        end
                        state_q <= h_idle;
                    end
                end
                h_dma: begin
                    if (link.dma_done) begin
                        dreq_q    <= 1'b0;
                        blocked_q <= link.dma_blocked;
                        state_q   <= h_idle;
                    end
                end
                default: begin
                    state_q <= h_idle;
                end
            endcase
            if (go && state_q != h_idle) begin
                refused_q <= 1'b1;
            end
        end
    end

    assign readdata       = readdata_q;
    assign waitrequest    = wait_q;
    assign link.reg_req   = req_q;
    assign link.reg_write = rw_q;
    assign link.reg_addr  = laddr_q;
    assign link.reg_wdata = wdata_q;
    assign link.dma_req   = dreq_q;
    assign link.dma_src   = src_q;
    assign link.dma_addr  = daddr_q;
endmodule

`default_nettype wire

// file: tb/prot_asserts.sv
/*
 * Assertions on the link that joins the two ends.
 * Assumes one clock and a device with the low region supported.
 */
`include "prot_defs.svh"
`default_nettype none

module prot_asserts #(
    parameter int RSVD_MSB = 19
) (
    // clock and reset
    input wire logic        clock,
    input wire logic        nrst,
    // register channel
    input wire logic        reg_req,
    input wire logic        reg_write,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_ack,
    input wire logic [31:0] reg_rdata,
    // request channel
    input wire logic        dma_req,
    input wire logic [1:0]  dma_src,
    input wire logic [31:0] dma_addr,
    input wire logic        dma_done,
    input wire logic        dma_blocked,
    input wire logic        prot_state
);
    import prot_pkg::*;
    localparam logic [31:0] MASK = ~((32'h1 << (RSVD_MSB + 1)) - 32'h1);
    logic        rt;
    logic        dt;
    logic        en_q;
    logic        bseen_q;
    logic        wr_q;
    logic        exp_q;
    logic [29:0] rsv_q;
    logic [7:0]  ad_q;
    logic [31:0] base_q;
    logic [31:0] lim_q;
    logic [31:0] lo;
    logic [31:0] hi;
    assign rt = reg_req && !reg_ack;
    assign dt = dma_req && !dma_done;
    assign lo = base_q & MASK;
    assign hi = lim_q | ~MASK;

    // shadow of what the device has been told
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            en_q <= 1'b0;
            rsv_q <= 30'h0;
            base_q <= 32'h0;
            lim_q <= 32'h0;
            bseen_q <= 1'b0;
            ad_q <= 8'h0;
            wr_q <= 1'b0;
        end else if (rt) begin
            ad_q <= reg_addr;
            wr_q <= reg_write;
            if (reg_write && reg_addr == `CTRL_OFS) begin
                en_q <= reg_wdata[31];
                rsv_q <= reg_wdata[30:1];
            end
            if (reg_write && reg_addr == `BASE_OFS) begin
                base_q <= reg_wdata;
                bseen_q <= 1'b1;
            end
            if (reg_write && reg_addr == `LIMIT_OFS) begin
                lim_q <= reg_wdata;
            end
        end
    end

    // verdict expected for the request taken last
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            exp_q <= 1'b0;
        end else if (dt) begin
            exp_q <= (dma_src == src_pci || dma_src == src_cxl_io) && en_q
                && lo <= hi && dma_addr >= lo && dma_addr <= hi;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    chk_ack_next: assert property (rt |=> reg_ack)
        else $error("register request not answered");
    chk_dma_verdict: assert property (
        dt |=> dma_done && dma_blocked == exp_q)
        else $error("request verdict wrong");
    chk_cache_pass: assert property (
        dt && dma_src == src_cxl_cache |=> !dma_blocked)
        else $error("cache access blocked");
    chk_walk_pass: assert property (
        dt && dma_src == src_walk |=> !dma_blocked)
        else $error("table walk blocked");
    chk_base_read: assert property (
        reg_ack && !wr_q && ad_q == `BASE_OFS |-> reg_rdata == lo)
        else $error("base readback wrong");
    chk_ctrl_read: assert property (
        reg_ack && !wr_q && ad_q == `CTRL_OFS
        |-> reg_rdata[31:1] == {en_q, rsv_q})
        else $error("control readback wrong");
    chk_state_on: assert property ($rose(prot_state) |-> en_q)
        else $error("status set while disabled");
    chk_no_early: assert property (
        $rose(en_q) |-> !prot_state ##1 !prot_state)
        else $error("status set before drain");
    chk_state_off: assert property ($fell(en_q) |-> ##1 !prot_state)
        else $error("status not cleared");
    chk_base_locked: assert property (
        rt && reg_write && reg_addr == `BASE_OFS |-> !prot_state)
        else $error("base written while enabled");
    chk_base_first: assert property (
        rt && reg_write && reg_addr == `CTRL_OFS && reg_wdata[31]
        |-> bseen_q)
        else $error("enabled before base written");
endmodule

`default_nettype wire

// file: tb/dma_protected_low_region_bench.sv
/*
 * Bench: Avalon-MM orders reach the device end through the host end.
 * Assumes default device parameters and a 10 MHz clock.
 */
`include "prot_defs.svh"
`default_nettype none

module dma_protected_low_region_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import prot_pkg::*;
    localparam int N = 19;
    localparam logic [31:0] MASK = ~((32'h1 << (N + 1)) - 32'h1);
    logic        clock;
    logic        nrst;
    logic        ce;
    logic [2:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        remap_enable;
    logic        inflight_empty;
    logic        remap_fault;
    logic        drain_request;
    logic        fault_report;
    logic        protect_state;
    logic        en_v;
    logic [31:0] base_v;
    logic [31:0] lim_v;
    integer      seed;
    int          num_errors = 0;
    int          total_checks = 0;
    int          cyc = 0;
    prot_link_if lnk ();

    prot_guard #(.RSVD_MSB(N)) i_prot_guard (
        .clock(clock), .nrst(nrst), .ce(ce), .link(lnk),
        .remap_enable(remap_enable), .inflight_empty(inflight_empty),
        .remap_fault(remap_fault), .drain_request(drain_request),
        .fault_report(fault_report), .protect_state(protect_state));
    prot_host i_prot_host (
        .clock(clock), .nrst(nrst), .ce(ce), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .link(lnk));
    prot_asserts #(.RSVD_MSB(N)) i_prot_asserts (
        .clock(clock), .nrst(nrst), .reg_req(lnk.reg_req),
        .reg_write(lnk.reg_write), .reg_addr(lnk.reg_addr),
        .reg_wdata(lnk.reg_wdata), .reg_ack(lnk.reg_ack),
        .reg_rdata(lnk.reg_rdata), .dma_req(lnk.dma_req),
        .dma_src(lnk.dma_src), .dma_addr(lnk.dma_addr),
        .dma_done(lnk.dma_done), .dma_blocked(lnk.dma_blocked),
        .prot_state(lnk.prot_state));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // a hung handshake ends here
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic av(input logic [2:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clock);
        address <= a;
        write <= w;
        read <= !w;
        writedata <= d;
        do @(posedge clock); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wait_idle(output logic [31:0] st);
        do av(`H_STATUS, 1'b0, 32'h0, st); while (st[`ST_BUSY] !== 1'b0);
    endtask

    task automatic lop(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] st,
                       output logic [31:0] q);
        av(`H_LADDR, 1'b1, {24'h0, a}, st);
        av(`H_LWDATA, 1'b1, d, st);
        av(`H_GO, 1'b1, w ? 32'h1 : 32'h2, st);
        wait_idle(st);
        av(`H_LRDATA, 1'b0, 32'h0, q);
    endtask

    task automatic waitst(input logic v);
        int n = 0;
        while (protect_state !== v && n < 40) begin
            @(posedge clock);
            n++;
        end
        check(protect_state, v);
    endtask

    // base_v and lim_v hold the decoded range
    function automatic logic blk_exp(input logic [1:0] s,
                                     input logic [31:0] a);
        return en_v && s < 2'h2 && base_v <= lim_v && a >= base_v &&
               a <= lim_v;
    endfunction

    // boundary addresses are where decode slips show
    function automatic logic [31:0] pick();
        case ($unsigned($random(seed)) % 5)
            0: return base_v;
            1: return base_v - 32'h1;
            2: return lim_v;
            3: return lim_v + 32'h1;
            default: return $random(seed);
        endcase
    endfunction

    task automatic dma(input logic [1:0] s, input logic [31:0] a);
        logic [31:0] st;
        logic        e;
        e = blk_exp(s, a);
        av(`H_DADDR, 1'b1, a, st);
        remap_enable <= 1'($random(seed));
        av(`H_GO, 1'b1, {26'h0, s, 4'h4}, st);
        remap_fault <= 1'b1;
        @(posedge clock);
        remap_fault <= 1'b0;
        #1 check(fault_report, !e);
        wait_idle(st);
        check(st[`ST_BLOCKED], e);
    endtask

    task automatic run(input logic [31:0] b, input logic [31:0] l);
        logic [31:0] st;
        logic [31:0] q;
        lop(1'b1, `CTRL_OFS, 32'h0, st, q);
        en_v = 1'b0;
        waitst(1'b0);
        lop(1'b1, `BASE_OFS, b, st, q);
        lop(1'b1, `LIMIT_OFS, l, st, q);
        base_v = b & MASK;
        lim_v = l | ~MASK;
        lop(1'b0, `BASE_OFS, 32'h0, st, q);
        check(q, b & MASK);
        lop(1'b1, `CTRL_OFS, 32'h8000_0000, st, q);
        en_v = 1'b1;
        repeat (6) @(posedge clock);
        check(protect_state, 1'b0);
        check(drain_request, 1'b1);
        inflight_empty <= 1'b1;
        waitst(1'b1);
        inflight_empty <= 1'b0;
        lop(1'b0, `CTRL_OFS, 32'h0, st, q);
        check(q[31:30], 2'h2);
        check(q[0], 1'b1);
        lop(1'b1, `BASE_OFS, 32'h0, st, q);
        check(st[`ST_REFUSED], 1'b1);
        repeat (12) dma(2'($random(seed)), pick());
        lop(1'b1, `CTRL_OFS, 32'h0, st, q);
        en_v = 1'b0;
        waitst(1'b0);
        repeat (4) dma(2'($random(seed)), pick());
    endtask

    initial begin
        logic [31:0] st;
        logic [31:0] q;
        seed = 32'he02e;
        nrst = 1'b0;
        ce = 1'b1;
        address = 3'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        remap_enable = 1'b0;
        inflight_empty = 1'b0;
        remap_fault = 1'b0;
        en_v = 1'b0;
        base_v = 32'h0;
        lim_v = 32'h0;
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        lop(1'b0, `CTRL_OFS, 32'h0, st, q);
        check(q, 32'h0);
        lop(1'b0, `BASE_OFS, 32'h0, st, q);
        check(q, 32'h0);
        lop(1'b1, `CTRL_OFS, 32'h8000_0000, st, q);
        check(st[`ST_REFUSED], 1'b1);
        check(protect_state, 1'b0);
        lop(1'b1, `BASE_OFS, 32'hffff_ffff, st, q);
        lop(1'b0, `BASE_OFS, 32'h0, st, q);
        check(q, MASK);
        run(32'h1234_5678, 32'h1234_5678);
        run($random(seed), $random(seed));
        run(32'h8000_0000, 32'h4000_0000);
        stop_test();
    end
endmodule

`default_nettype wire
